// ---- analog_mux_defs.vh ----
`ifndef ANALOG_MUX_DEFS_VH
`define ANALOG_MUX_DEFS_VH

// Register byte addresses
`define AMX_ADDR_W            12
`define AMX_OFS_SELECT        12'h000
`define AMX_OFS_STATUS        12'h004
`define AMX_OFS_MASK          12'h008
`define AMX_OFS_RESULT        12'h00c
`define AMX_OFS_FLAG_CLEAR    12'h010

// Select register fields
`define AMX_SEL_W             8
`define AMX_BIT_DIRECT        7
`define AMX_BIT_DIVIDED       6
`define AMX_BIT_SWAP          5
`define AMX_BIT_VREF          4
`define AMX_CHAN_HI           3
`define AMX_CHAN_LO           0
`define AMX_SEL_RESET         8'h80

// Status and mask fields
`define AMX_EVT_W             3
`define AMX_EVT_CMP1          0
`define AMX_EVT_CMP2          1
`define AMX_EVT_SWAP          2
`define AMX_STATUS_RESET      3'h0
`define AMX_MASK_RESET        3'h0

// Result register fields
`define AMX_RES_CMP1          0
`define AMX_RES_CMP2          1

// Flag clear fields
`define AMX_CLR_CMP1          0
`define AMX_CLR_CMP2          1

`endif

// ---- cmp_polarity_fix.v ----
`default_nettype none

module cmp_polarity_fix (
  input  wire mclk_in,
  input  wire arst_n_in,
  input  wire ce_in,
  input  wire raw_in,
  input  wire swap_in,
  output reg  result_out,
  output wire rise_out
);

  wire next_result;

  // Swapped inputs invert the raw output, so undo it here
  assign next_result = raw_in ^ swap_in;

  always @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      result_out <= 1'b0;
    end else if (ce_in) begin
      result_out <= next_result;
    end
  end

  // Flag phase follows the pins in either swap state
  assign rise_out = ce_in & next_result & ~result_out;

endmodule

`default_nettype wire

// ---- chan_bus_decode.v ----
`default_nettype none

module chan_bus_decode (
  input  wire       direct_in,
  input  wire       divided_in,
  input  wire       vref_in,
  input  wire [3:0] chan_in,
  output wire [3:0] pin_sw_out,
  output wire       vdd_sw_out,
  output wire       gnd_sw_out,
  output wire       src_hold_out,
  output wire       src_half_out,
  output wire       src_direct_out,
  output wire       src_diode_out
);

  wire no_chan;

  assign no_chan = (chan_in == 4'h0);

  // One switch per pin, any mix allowed
  assign pin_sw_out = chan_in;

  // Supply only with no channel selected
  assign vdd_sw_out = vref_in & no_chan;

  // Ground is the idle default of the bus
  assign gnd_sw_out = ~vref_in & no_chan;

  // Comparator 2 negative input source
  assign src_hold_out   = ~direct_in & ~divided_in;
  assign src_half_out   = ~direct_in &  divided_in;
  assign src_direct_out =  direct_in & ~divided_in;
  assign src_diode_out  =  direct_in &  divided_in;

endmodule

`default_nettype wire

// ---- analog_channel_mux_control.v ----
// Notes on behaviour
// - Reset sets the direct-sample bit and clears the divided-sample bit.
// - Reset clears all channel bits so the bus and sample cap go to ground.
// - Swap set exchanges comparator inputs and inverts their outputs.
// - Swap changes only offset polarity; flags keep phase with the pins.
// - A result is high only when its positive pin exceeds its negative pin.
// - Reference set connects supply only when no channel bit is set.
// - Reference clear never connects supply; the bit resets to zero.
// - Channel bits are independent and may be combined freely.
// - Each channel bit closes exactly one pin switch.
// - Ground switch closes only when reference and channels are all zero.
// - The two sample bits pick hold, half bus, bus or diode for cmp 2.
//
// The address map and the APB slave port were chosen for this implementation.
`include "analog_mux_defs.vh"
`default_nettype none

module analog_channel_mux_control (
  input  wire        mclk_in,
  input  wire        arst_n_in,
  input  wire        ce_in,
  input  wire        psel_in,
  input  wire        penable_in,
  input  wire        pwrite_in,
  input  wire [11:0] paddr_in,
  input  wire [31:0] pwdata_in,
  input  wire [3:0]  pstrb_in,
  output reg  [31:0] prdata_out,
  output wire        pready_out,
  output wire        pslverr_out,
  input  wire        cmp1_raw_in,
  input  wire        cmp2_raw_in,
  output wire        comparator_swap_out,
  output wire        analog_pin_1_sw_out,
  output wire        analog_pin_2_sw_out,
  output wire        analog_pin_3_sw_out,
  output wire        analog_pin_4_sw_out,
  output wire        vdd_sw_out,
  output wire        internal_analog_ground_sw_out,
  output wire        cmp2_src_hold_out,
  output wire        cmp2_src_half_out,
  output wire        cmp2_src_direct_out,
  output wire        cmp2_src_diode_out,
  output wire        cmp1_flag_out,
  output wire        cmp2_flag_out,
  output wire        irq_out
);

  reg  [7:0]  analog_channel_select;
  reg  [2:0]  event_status;
  reg  [2:0]  event_mask;
  reg         err_q;
  reg         rd_captured;
  reg  [2:0]  next_status;
  reg  [31:0] next_rdata;
  reg         next_err;

  wire        setup_phase;
  wire        access_phase;
  wire        wr_commit;
  wire        wr_select;
  wire        wr_status;
  wire        wr_mask;
  wire        wr_flag_clear;
  wire        rd_fetch;
  wire        lane0;
  wire        cmp1_result;
  wire        cmp2_result;
  wire        cmp1_rise;
  wire        cmp2_rise;
  wire        swap_toggle;
  wire [2:0]  set_evt;
  wire [2:0]  clr_evt;
  wire [3:0]  pin_sw;
  wire        direct_sample_sel;
  wire        divided_sample_sel;
  wire        comparator_swap;
  wire        vref_sel;
  wire [3:0]  chan_sel;

  function addr_is;
    input [11:0] addr;
    input [11:0] ofs;
    begin
      addr_is = (addr == ofs);
    end
  endfunction

  function addr_known;
    input [11:0] addr;
    begin
      addr_known = addr_is(addr, `AMX_OFS_SELECT) |
                   addr_is(addr, `AMX_OFS_STATUS) |
                   addr_is(addr, `AMX_OFS_MASK) |
                   addr_is(addr, `AMX_OFS_RESULT) |
                   addr_is(addr, `AMX_OFS_FLAG_CLEAR);
    end
  endfunction

  function write_to;
    input        commit;
    input [11:0] addr;
    input [11:0] ofs;
    begin
      write_to = commit & addr_is(addr, ofs);
    end
  endfunction

  assign setup_phase  = psel_in & ~penable_in;
  assign access_phase = psel_in & penable_in;

  // Setup lost to a low ce_in leaves no read data, so stall one cycle
  assign rd_fetch    = setup_phase | (access_phase & ~rd_captured);
  assign pready_out  = ce_in & ~(access_phase & ~rd_captured);
  assign pslverr_out = access_phase & rd_captured & err_q;
  assign lane0       = pstrb_in[0];
  assign wr_commit   = ce_in & access_phase & rd_captured & pwrite_in &
                       ~err_q & lane0;

  // Strobes as wires keep every operand in view of the assigns below
  assign wr_select     = write_to(wr_commit, paddr_in, `AMX_OFS_SELECT);
  assign wr_status     = write_to(wr_commit, paddr_in, `AMX_OFS_STATUS);
  assign wr_mask       = write_to(wr_commit, paddr_in, `AMX_OFS_MASK);
  assign wr_flag_clear = write_to(wr_commit, paddr_in, `AMX_OFS_FLAG_CLEAR);

  assign direct_sample_sel  = analog_channel_select[`AMX_BIT_DIRECT];
  assign divided_sample_sel = analog_channel_select[`AMX_BIT_DIVIDED];
  assign comparator_swap    = analog_channel_select[`AMX_BIT_SWAP];
  assign vref_sel           = analog_channel_select[`AMX_BIT_VREF];
  assign chan_sel = analog_channel_select[`AMX_CHAN_HI:`AMX_CHAN_LO];

  // Sample bits and channel bits share one write; ordering is software's
  always @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      analog_channel_select <= `AMX_SEL_RESET;
    end else if (wr_select) begin
      analog_channel_select <= pwdata_in[7:0];
    end
  end

  always @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      event_mask <= `AMX_MASK_RESET;
    end else if (wr_mask) begin
      event_mask <= pwdata_in[2:0];
    end
  end

  // A swap change can fake a comparator edge, so it is flagged as well
  assign swap_toggle = wr_select &
                       (pwdata_in[`AMX_BIT_SWAP] != comparator_swap);

  assign set_evt[`AMX_EVT_CMP1] = cmp1_rise;
  assign set_evt[`AMX_EVT_CMP2] = cmp2_rise;
  assign set_evt[`AMX_EVT_SWAP] = swap_toggle;

  assign clr_evt[`AMX_EVT_CMP1] =
    (wr_status & pwdata_in[`AMX_EVT_CMP1]) |
    (wr_flag_clear & pwdata_in[`AMX_CLR_CMP1]);
  assign clr_evt[`AMX_EVT_CMP2] =
    (wr_status & pwdata_in[`AMX_EVT_CMP2]) |
    (wr_flag_clear & pwdata_in[`AMX_CLR_CMP2]);
  assign clr_evt[`AMX_EVT_SWAP] =
    wr_status & pwdata_in[`AMX_EVT_SWAP];

  // New event beats a clear in the same cycle
  always @* begin
    next_status = (event_status & ~clr_evt) | set_evt;
  end

  always @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      event_status <= `AMX_STATUS_RESET;
    end else if (ce_in) begin
      event_status <= next_status;
    end
  end

  assign irq_out = |(event_status & event_mask);
  assign cmp1_flag_out = event_status[`AMX_EVT_CMP1];
  assign cmp2_flag_out = event_status[`AMX_EVT_CMP2];

  // Read data is captured in the setup cycle so it leaves a flip-flop
  always @* begin
    next_rdata = 32'h00000000;
    next_err   = ~addr_known(paddr_in);
    if (addr_is(paddr_in, `AMX_OFS_SELECT)) begin
      next_rdata[7:0] = analog_channel_select;
    end
    if (addr_is(paddr_in, `AMX_OFS_STATUS)) begin
      next_rdata[2:0] = event_status;
    end
    if (addr_is(paddr_in, `AMX_OFS_MASK)) begin
      next_rdata[2:0] = event_mask;
    end
    if (addr_is(paddr_in, `AMX_OFS_RESULT)) begin
      next_rdata[`AMX_RES_CMP1] = cmp1_result;
      next_rdata[`AMX_RES_CMP2] = cmp2_result;
    end
  end

  always @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      prdata_out  <= 32'h00000000;
      err_q       <= 1'b0;
      rd_captured <= 1'b0;
    end else if (ce_in) begin
      if (rd_fetch) begin
        prdata_out  <= pwrite_in ? 32'h00000000 : next_rdata;
        err_q       <= next_err;
        rd_captured <= 1'b1;
      end else begin
        rd_captured <= 1'b0;
      end
    end
  end

  // Swap drives the analog input exchange
  assign comparator_swap_out = comparator_swap;

  cmp_polarity_fix u_cmp1 (
    .mclk_in    (mclk_in),
    .arst_n_in  (arst_n_in),
    .ce_in      (ce_in),
    .raw_in     (cmp1_raw_in),
    .swap_in    (comparator_swap),
    .result_out (cmp1_result),
    .rise_out   (cmp1_rise)
  );

  cmp_polarity_fix u_cmp2 (
    .mclk_in    (mclk_in),
    .arst_n_in  (arst_n_in),
    .ce_in      (ce_in),
    .raw_in     (cmp2_raw_in),
    .swap_in    (comparator_swap),
    .result_out (cmp2_result),
    .rise_out   (cmp2_rise)
  );

  chan_bus_decode u_decode (
    .direct_in      (direct_sample_sel),
    .divided_in     (divided_sample_sel),
    .vref_in        (vref_sel),
    .chan_in        (chan_sel),
    .pin_sw_out     (pin_sw),
    .vdd_sw_out     (vdd_sw_out),
    .gnd_sw_out     (internal_analog_ground_sw_out),
    .src_hold_out   (cmp2_src_hold_out),
    .src_half_out   (cmp2_src_half_out),
    .src_direct_out (cmp2_src_direct_out),
    .src_diode_out  (cmp2_src_diode_out)
  );

  assign analog_pin_1_sw_out = pin_sw[0];
  assign analog_pin_2_sw_out = pin_sw[1];
  assign analog_pin_3_sw_out = pin_sw[2];
  assign analog_pin_4_sw_out = pin_sw[3];

endmodule

`default_nettype wire

// ---- dummy_end_marker_none.v ----
`default_nettype none
`default_nettype wire

// ---- amx_sva.sv ----
`default_nettype none
module amx_sva (
  input wire logic mclk_in,
  input wire logic arst_n_in,
  input wire logic ce_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic pready_out,
  input wire logic cmp1_raw_in,
  input wire logic cmp2_raw_in,
  input wire logic comparator_swap_out,
  input wire logic analog_pin_1_sw_out,
  input wire logic analog_pin_2_sw_out,
  input wire logic analog_pin_3_sw_out,
  input wire logic analog_pin_4_sw_out,
  input wire logic vdd_sw_out,
  input wire logic internal_analog_ground_sw_out,
  input wire logic cmp2_src_hold_out,
  input wire logic cmp2_src_half_out,
  input wire logic cmp2_src_direct_out,
  input wire logic cmp2_src_diode_out,
  input wire logic cmp1_flag_out,
  input wire logic cmp2_flag_out
);
  timeunit 1ns;
  timeprecision 1ps;
  wire [3:0] pins = {analog_pin_4_sw_out, analog_pin_3_sw_out,
    analog_pin_2_sw_out, analog_pin_1_sw_out};
  wire       x1 = cmp1_raw_in ^ comparator_swap_out;
  wire       x2 = cmp2_raw_in ^ comparator_swap_out;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);
  sequence s_up1; (!x1 && ce_in) ##1 (x1 && ce_in); endsequence
  sequence s_up2; (!x2 && ce_in) ##1 (x2 && ce_in); endsequence
  property p_rst; $rose(arst_n_in) |-> internal_analog_ground_sw_out &&
    cmp2_src_direct_out && !comparator_swap_out && pins == 4'h0; endproperty
  property p_vdd; vdd_sw_out |-> pins == 4'h0; endproperty
  property p_gnd;
    internal_analog_ground_sw_out == (pins == 4'h0 && !vdd_sw_out);
  endproperty
  property p_src; $onehot({cmp2_src_hold_out, cmp2_src_half_out,
    cmp2_src_direct_out, cmp2_src_diode_out}); endproperty
  property p_swap; $changed(comparator_swap_out) |-> $past(psel_in &&
    penable_in && pwrite_in && pready_out); endproperty
  property p_pins; $changed(pins) |-> $past(psel_in && penable_in &&
    pwrite_in && pready_out); endproperty
  property p_flag1; s_up1 |=> cmp1_flag_out; endproperty
  property p_flag2; s_up2 |=> cmp2_flag_out; endproperty
  a_rst: assert property (p_rst)
    else $error("wrong state after reset");
  a_vdd: assert property (p_vdd)
    else $error("supply and pin on together");
  a_gnd: assert property (p_gnd)
    else $error("ground switch wrong");
  a_src: assert property (p_src)
    else $error("source select not one-hot");
  a_swap: assert property (p_swap)
    else $error("swap moved without a write");
  a_pins: assert property (p_pins)
    else $error("pin switch moved without a write");
  a_flag1: assert property (p_flag1)
    else $error("first flag missed");
  a_flag2: assert property (p_flag2)
    else $error("second flag missed");
endmodule
bind analog_channel_mux_control amx_sva u_sva (.*);
`default_nettype wire

// ---- amx_partner.sv ----
`default_nettype none
module amx_partner (
  input  wire logic        swap_in,
  input  wire logic [31:0] v_in,
  output logic             raw1_out,
  output logic             raw2_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Swapped parts see their pins exchanged; inversion is left to the device
  assign raw1_out = swap_in ? v_in[23:16] > v_in[31:24]
                            : v_in[31:24] > v_in[23:16];
  assign raw2_out = swap_in ? v_in[7:0] > v_in[15:8]
                            : v_in[15:8] > v_in[7:0];
endmodule
`default_nettype wire

// ---- analog_channel_mux_control_tb_top.sv ----
`include "analog_mux_defs.vh"
`default_nettype none
module analog_channel_mux_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk_in = 1'b0;
  logic        arst_n_in, ce_in, psel_in, penable_in, pwrite_in, rerr;
  logic [11:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, rdata, v;
  logic [3:0]  pstrb_in;
  logic        pready_out, pslverr_out, cmp1_raw_in, cmp2_raw_in, irq_out;
  logic        comparator_swap_out, vdd_sw_out, internal_analog_ground_sw_out;
  logic        analog_pin_1_sw_out, analog_pin_2_sw_out;
  logic        analog_pin_3_sw_out, analog_pin_4_sw_out;
  logic        cmp1_flag_out, cmp2_flag_out, cmp2_src_hold_out;
  logic        cmp2_src_half_out, cmp2_src_direct_out, cmp2_src_diode_out;
  int          failures = 0;
  int          total_checks = 0;
  int          k;
  // Select value beside expected decode; sample bits cleared before channels
  logic [18:0] rows [8] = '{19'h40102, 19'h00108, 19'h20104, 19'h60101,
                           19'h08208, 19'h0f8f8, 19'h02858, 19'h154a8};
  wire  [31:0] dec = {21'h0, comparator_swap_out, vdd_sw_out,
    internal_analog_ground_sw_out, analog_pin_4_sw_out, analog_pin_3_sw_out,
    analog_pin_2_sw_out, analog_pin_1_sw_out, cmp2_src_hold_out,
    cmp2_src_half_out, cmp2_src_direct_out, cmp2_src_diode_out};
  wire  [31:0] fl = {29'h0, irq_out, cmp2_flag_out, cmp1_flag_out};
  analog_channel_mux_control u_dut (.*);
  amx_partner u_cmp (.swap_in(comparator_swap_out), .v_in(v),
    .raw1_out(cmp1_raw_in), .raw2_out(cmp2_raw_in));
  initial forever #2.5 mclk_in = ~mclk_in;
  task conclude;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    total_checks++;
    if (g !== x) begin
      $display("MISMATCH %s expected %h seen %h", n, x, g);
      failures++;
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge mclk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge mclk_in);
    penable_in <= 1'b1;
    // Request stands until pready is seen high at a rising edge
    for (i = 0; i < 20; i++) begin
      @(posedge mclk_in);
      if (pready_out === 1'b1) break;
    end
    if (i == 20) begin
      failures++;
      conclude();
    end
    rdata = prdata_out;
    rerr = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task settle(input logic [31:0] nv);
    @(posedge mclk_in);
    v <= nv;
    repeat (3) @(posedge mclk_in);
    @(negedge mclk_in);
  endtask
  initial begin
    {arst_n_in, psel_in, penable_in, pwrite_in} = 4'h0;
    ce_in = 1'b1;
    pstrb_in = 4'hf;
    paddr_in = 12'h0;
    pwdata_in = 32'h0;
    v = 32'h0;
    repeat (5) @(posedge mclk_in);
    arst_n_in <= 1'b1;
    @(negedge mclk_in);
    chk("reset decode", 32'h102, dec);
    apb(1'b0, `AMX_OFS_SELECT, 32'h0);
    chk("reset select", 32'h80, rdata);
    for (k = 0; k < 8; k++) begin
      apb(1'b1, `AMX_OFS_SELECT, {24'h0, rows[k][18:11]});
      @(negedge mclk_in);
      chk("decode", {21'h0, rows[k][10:0]}, dec);
      apb(1'b0, `AMX_OFS_SELECT, 32'h0);
      chk("select", {24'h0, rows[k][18:11]}, rdata);
    end
    apb(1'b1, 12'h100, 32'hff);
    chk("unmapped error", 32'h1, {31'h0, rerr});
    apb(1'b0, `AMX_OFS_SELECT, 32'h0);
    chk("select kept", 32'h2a, rdata);
    @(posedge mclk_in);
    pstrb_in <= 4'he;
    apb(1'b1, `AMX_OFS_SELECT, 32'h0);
    pstrb_in <= 4'hf;
    apb(1'b0, `AMX_OFS_SELECT, 32'h0);
    chk("strobe off", 32'h2a, rdata);
    apb(1'b1, `AMX_OFS_SELECT, 32'h0);
    apb(1'b1, `AMX_OFS_FLAG_CLEAR, 32'h3);
    apb(1'b1, `AMX_OFS_STATUS, 32'h7);
    settle(32'h50282850);
    chk("flag masked", 32'h1, fl);
    apb(1'b0, `AMX_OFS_RESULT, 32'h0);
    chk("result", 32'h1, rdata);
    apb(1'b1, `AMX_OFS_MASK, 32'h1);
    @(negedge mclk_in);
    chk("irq raised", 32'h5, fl);
    apb(1'b1, `AMX_OFS_STATUS, 32'h1);
    @(negedge mclk_in);
    chk("irq cleared", 32'h0, fl);
    // Swap toggled only while no flag is awaited
    apb(1'b1, `AMX_OFS_SELECT, 32'h20);
    apb(1'b1, `AMX_OFS_FLAG_CLEAR, 32'h3);
    @(negedge mclk_in);
    chk("swap no flag", 32'h0, fl);
    apb(1'b0, `AMX_OFS_STATUS, 32'h0);
    chk("swap event", 32'h4, rdata);
    settle(32'h28505028);
    chk("swap phase", 32'h2, fl);
    apb(1'b0, `AMX_OFS_RESULT, 32'h0);
    chk("result swapped", 32'h2, rdata);
    apb(1'b1, `AMX_OFS_MASK, 32'h2);
    @(negedge mclk_in);
    chk("irq second", 32'h6, fl);
    @(posedge mclk_in);
    ce_in <= 1'b0;
    settle(32'h50282850);
    chk("frozen", 32'h6, fl);
    @(posedge mclk_in);
    ce_in <= 1'b1;
    repeat (2) @(posedge mclk_in);
    @(negedge mclk_in);
    chk("thawed", 32'h7, fl);
    @(posedge mclk_in);
    arst_n_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    arst_n_in <= 1'b1;
    @(negedge mclk_in);
    chk("rerun decode", 32'h102, dec);
    conclude();
  end
endmodule
`default_nettype wire
